// ==== common/ioc_pkg.sv ====
// constants and types shared by the io cell capture/output logic
package ioc_pkg;

  // system clock
  localparam int CLK_PERIOD_NS = 25;
  localparam int CLK_FREQ_KHZ = 40000;

  // divider producing the early and the regular global clock ticks
  localparam int DIV_DEFAULT = 4;
  localparam int EARLY_LEAD_DEFAULT = 1;
  localparam int PHASE_W = 8;

  // soft start-up: least time the first output activation stays slew limited
  localparam int SOFT_START_NS = 1000;
  localparam int SOFT_START_CYCLES_RAW = (SOFT_START_NS * CLK_FREQ_KHZ + 999999) / 1000000;
  localparam int SOFT_START_CYCLES = (SOFT_START_CYCLES_RAW < 1) ? 1 : SOFT_START_CYCLES_RAW;
  localparam int SOFT_CNT_W = 16;

  // output clock level that selects the output data
  localparam logic OUT_DATA_LEVEL_DEFAULT = 1'h1;

  // reset values
  localparam logic [PHASE_W-1:0] PHASE_RESET = 8'h00;
  localparam logic [SOFT_CNT_W-1:0] SOFT_CNT_RESET = 16'h0000;
  localparam logic PAD_OE_RESET = 1'h0;
  localparam logic SLEW_FAST_RESET = 1'h0;
  localparam logic OCLK_RESET = 1'h0;

  // which storage element the shared clock enable gates
  typedef enum logic [1:0] {
    IOC_CE_INPUT = 2'h0,
    IOC_CE_OUTPUT = 2'h1,
    IOC_CE_BOTH = 2'h2,
    IOC_CE_NONE = 2'h3
  } ioc_ce_target_e;

  // output multiplexer function
  typedef enum logic {
    IOC_OMUX_SELECT = 1'h0,
    IOC_OMUX_AND = 1'h1
  } ioc_omux_e;

  // soft start-up sequence
  typedef enum logic [1:0] {
    IOC_ST_CONFIG = 2'h0,
    IOC_ST_ARMED = 2'h1,
    IOC_ST_LIMIT = 2'h2,
    IOC_ST_NORMAL = 2'h3
  } ioc_start_e;

endpackage : ioc_pkg

// ==== common/ioc_store_if.sv ====
// carrier between the cell top and one storage element
`timescale 1ns/1ps
interface ioc_store_if #(
  parameter int W = 1
);
  logic tick;
  logic level;
  logic is_latch;
  logic gated;
  logic ce;
  logic [W-1:0] d;
  logic [W-1:0] q;

  modport ctrl (output tick, output level, output is_latch, output gated, output ce,
    output d, input q);
  modport store (input tick, input level, input is_latch, input gated, input ce,
    input d, output q);
endinterface : ioc_store_if

// ==== hw/ioc_cell.sv ====
// io cell: input capture, output mux and soft start-up slew control
// Function
// - one clock enable shared by both elements
// - config picks input, output or both gated
// - inactive enable at edge keeps stored value
// - enable active high, not invertible, open means on
// - early clock ahead of global clock available
// - optional fast-capture latch on early clock only
// - fast latch on early, input element on global
// - output clock steers data or enable to pad
// - alternative mode ANDs the two mux inputs
// - first activation slew limited, then per-output
`timescale 1ns/1ps
module ioc_cell #(
  parameter int W = 1,
  parameter int DIV = ioc_pkg::DIV_DEFAULT,
  parameter int EARLY_LEAD = ioc_pkg::EARLY_LEAD_DEFAULT,
  parameter logic OUT_DATA_LEVEL = ioc_pkg::OUT_DATA_LEVEL_DEFAULT
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic [W-1:0] pad_i,
  input wire logic [W-1:0] user_out,
  input wire logic user_oe,
  input wire logic cell_clock_enable,
  input wire logic cell_clock_enable_connected,
  input wire ioc_pkg::ioc_ce_target_e ce_target,
  input wire logic in_is_latch,
  input wire logic fast_capture_en,
  input wire ioc_pkg::ioc_omux_e omux_mode,
  input wire logic config_done,
  input wire logic slew_fast_cfg,
  output logic [W-1:0] user_in,
  output logic [W-1:0] pad_o,
  output logic pad_oe,
  output logic pad_slew_fast,
  output logic output_clk
);
  import ioc_pkg::*;

  typedef struct packed {
    logic [PHASE_W-1:0] phase;
    logic [W-1:0] fast_q;
    ioc_start_e start;
    logic [SOFT_CNT_W-1:0] soft_cnt;
    logic [W-1:0] pad_o;
    logic pad_oe;
    logic slew_fast;
    logic oclk;
  } ioc_cell_s;

  localparam logic [PHASE_W-1:0] LAST_PHASE = PHASE_W'(DIV - 1);
  localparam logic [PHASE_W-1:0] EARLY_PHASE = PHASE_W'(0);
  localparam logic [PHASE_W-1:0] GLOBAL_PHASE = PHASE_W'(EARLY_LEAD);
  localparam logic [PHASE_W-1:0] GLOBAL_END = PHASE_W'(EARLY_LEAD + DIV / 2);
  localparam logic [SOFT_CNT_W-1:0] SOFT_LAST = SOFT_CNT_W'(SOFT_START_CYCLES - 1);

  ioc_cell_s st_reg;
  ioc_cell_s st_next;

  logic early_tick;
  logic global_tick;
  logic global_level;
  logic ce_eff;
  logic [W-1:0] omux;

  ioc_store_if #(.W(W)) in_if ();
  ioc_store_if #(.W(W)) out_if ();

  if (W < 1) begin : g_bad_w
    $error("ioc_cell: W must be at least 1");
  end
  if (DIV < 4 || (DIV % 2) != 0 || DIV > 255) begin : g_bad_div
    $error("ioc_cell: DIV must be even and within 4..254");
  end
  if (EARLY_LEAD < 1 || EARLY_LEAD >= DIV / 2) begin : g_bad_lead
    $error("ioc_cell: EARLY_LEAD must be within 1..DIV/2-1");
  end

  // early clock leads the regular global clock by EARLY_LEAD cycles
  assign early_tick = (st_reg.phase == EARLY_PHASE);
  assign global_tick = (st_reg.phase == GLOBAL_PHASE);
  assign global_level = (st_reg.phase >= GLOBAL_PHASE) && (st_reg.phase < GLOBAL_END);

  // no inversion option; an open enable reads as active
  assign ce_eff = !cell_clock_enable_connected || cell_clock_enable;

  // input element, fed directly or from the fast-capture latch
  assign in_if.tick = global_tick;
  assign in_if.level = global_level;
  assign in_if.is_latch = in_is_latch;
  assign in_if.ce = ce_eff;
  assign in_if.gated = (ce_target == IOC_CE_INPUT) || (ce_target == IOC_CE_BOTH);
  assign in_if.d = fast_capture_en ? st_reg.fast_q : pad_i;

  // output element, flip-flop on the global clock
  assign out_if.tick = global_tick;
  assign out_if.level = global_level;
  assign out_if.is_latch = 1'h0;
  assign out_if.ce = ce_eff;
  assign out_if.gated = (ce_target == IOC_CE_OUTPUT) || (ce_target == IOC_CE_BOTH);
  assign out_if.d = user_out;

  ioc_store #(.W(W)) u_in_store (
    .clk(clk),
    .reset(reset),
    .s(in_if.store)
  );

  ioc_store #(.W(W)) u_out_store (
    .clk(clk),
    .reset(reset),
    .s(out_if.store)
  );

  // pad multiplexer: select by output clock, or AND of both inputs
  always_comb begin
    if (omux_mode == IOC_OMUX_AND) begin
      omux = out_if.q & {W{ce_eff}};
    end else if (st_reg.oclk == OUT_DATA_LEVEL) begin
      omux = out_if.q;
    end else begin
      omux = {W{ce_eff}};
    end
  end

  always_comb begin
    st_next = st_reg;

    if (st_reg.phase == LAST_PHASE) begin
      st_next.phase = '0;
    end else begin
      st_next.phase = st_reg.phase + PHASE_W'(1);
    end

    // fast-capture latch sees only the early clock
    if (fast_capture_en && early_tick) begin
      st_next.fast_q = pad_i;
    end

    st_next.oclk = global_level;
    st_next.pad_o = omux;

    case (st_reg.start)
      IOC_ST_CONFIG: begin
        if (config_done) begin
          st_next.start = IOC_ST_ARMED;
        end
      end
      IOC_ST_ARMED: begin
        if (user_oe) begin
          st_next.start = IOC_ST_LIMIT;
          st_next.soft_cnt = '0;
        end
      end
      IOC_ST_LIMIT: begin
        if (st_reg.soft_cnt == SOFT_LAST) begin
          st_next.start = IOC_ST_NORMAL;
        end else begin
          st_next.soft_cnt = st_reg.soft_cnt + SOFT_CNT_W'(1);
        end
      end
      IOC_ST_NORMAL: begin
        st_next.start = IOC_ST_NORMAL;
      end
      default: begin
        st_next.start = IOC_ST_CONFIG;
      end
    endcase

    // outputs stay off until configuration has finished
    st_next.pad_oe = user_oe && (st_reg.start != IOC_ST_CONFIG);
    // limited slew until the first activation has passed
    if (st_next.start == IOC_ST_NORMAL) begin
      st_next.slew_fast = slew_fast_cfg;
    end else begin
      st_next.slew_fast = 1'h0;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      st_reg.phase <= PHASE_RESET;
      st_reg.fast_q <= '0;
      st_reg.start <= IOC_ST_CONFIG;
      st_reg.soft_cnt <= SOFT_CNT_RESET;
      st_reg.pad_o <= '0;
      st_reg.pad_oe <= PAD_OE_RESET;
      st_reg.slew_fast <= SLEW_FAST_RESET;
      st_reg.oclk <= OCLK_RESET;
    end else begin
      st_reg <= st_next;
    end
  end

  assign user_in = in_if.q;
  assign pad_o = st_reg.pad_o;
  assign pad_oe = st_reg.pad_oe;
  assign pad_slew_fast = st_reg.slew_fast;
  assign output_clk = st_reg.oclk;

endmodule : ioc_cell

// ==== hw/ioc_store.sv ====
// one io cell storage element: flip-flop or latch with optional clock enable
`timescale 1ns/1ps
module ioc_store #(
  parameter int W = 1
) (
  input wire logic clk,
  input wire logic reset,
  ioc_store_if.store s
);
  import ioc_pkg::*;

  typedef struct packed {
    logic [W-1:0] q;
  } ioc_store_s;

  ioc_store_s st_reg;
  ioc_store_s st_next;
  logic load;

  if (W < 1) begin : g_bad_w
    $error("ioc_store: W must be at least 1");
  end

  assign s.q = st_reg.q;

  always_comb begin
    st_next = st_reg;
    // edge for a flip-flop, transparent level for a latch
    load = s.is_latch ? s.level : s.tick;
    // inactive enable holds the value when the element is gated
    if (load && (!s.gated || s.ce)) begin
      st_next.q = s.d;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

endmodule : ioc_store

// ==== testbench/ioc_cell_monitor.sv ====
// port assertions for the io cell
`timescale 1ns/1ps
module ioc_cell_monitor
  import ioc_pkg::*;
#(
  parameter int W = 1,
  parameter logic OUT_DATA_LEVEL = 1'h1
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic cell_clock_enable,
  input wire logic cell_clock_enable_connected,
  input wire ioc_pkg::ioc_ce_target_e ce_target,
  input wire ioc_pkg::ioc_omux_e omux_mode,
  input wire logic config_done,
  input wire logic slew_fast_cfg,
  input wire logic [W-1:0] user_in,
  input wire logic [W-1:0] pad_o,
  input wire logic pad_oe,
  input wire logic pad_slew_fast,
  input wire logic output_clk
);
  logic ce_eff;
  logic in_off;
  logic cfg_reg;
  logic [5:0] soft_reg;
  assign ce_eff = !cell_clock_enable_connected | cell_clock_enable;
  assign in_off = (ce_target == IOC_CE_INPUT || ce_target == IOC_CE_BOTH) && !ce_eff;
  // cycles since first output activation
  always_ff @(posedge clk) begin
    if (reset) begin
      cfg_reg <= 1'h0;
      soft_reg <= 6'h00;
    end else begin
      cfg_reg <= cfg_reg | config_done;
      if ((pad_oe || soft_reg != 6'h00) && soft_reg != 6'h3F)
        soft_reg <= soft_reg + 6'h01;
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  chk_oe_start: assert property (!cfg_reg |-> !pad_oe)
    else $error("oe before start-up");
  chk_slew_soft: assert property (
    soft_reg != 6'h00 && soft_reg < 6'(SOFT_START_CYCLES) |-> !pad_slew_fast)
    else $error("slew not limited");
  chk_slew_release: assert property (
    soft_reg == 6'(SOFT_START_CYCLES) |-> pad_slew_fast == $past(slew_fast_cfg))
    else $error("slew not released after soft start");
  chk_slew_cfg: assert property ($rose(pad_slew_fast) |-> $past(slew_fast_cfg))
    else $error("slew not from option");
  chk_mux_enable: assert property (
    (omux_mode == IOC_OMUX_SELECT && output_clk != OUT_DATA_LEVEL) ##1
    (output_clk != OUT_DATA_LEVEL) |-> pad_o == {W{$past(ce_eff)}})
    else $error("mux enable path");
  chk_and_gate: assert property (omux_mode == IOC_OMUX_AND && !ce_eff |=> pad_o == '0)
    else $error("and gate");
  chk_clk_high: assert property ($rose(output_clk) |-> output_clk [*2] ##1 !output_clk)
    else $error("clock high time");
  chk_clk_period: assert property ($rose(output_clk) |-> ##4 $rose(output_clk))
    else $error("clock period");
  chk_in_hold: assert property ($past(in_off) |-> $stable(user_in))
    else $error("gated input moved");
  cover property (omux_mode == IOC_OMUX_AND && pad_o != '0);
  cover property ($rose(pad_slew_fast));
  cover property ($past(in_off) && user_in != '0);
endmodule : ioc_cell_monitor
bind ioc_cell ioc_cell_monitor #(.W(W), .OUT_DATA_LEVEL(OUT_DATA_LEVEL)) u_ioc_cell_monitor (
  .clk(clk),
  .reset(reset),
  .cell_clock_enable(cell_clock_enable),
  .cell_clock_enable_connected(cell_clock_enable_connected),
  .ce_target(ce_target),
  .omux_mode(omux_mode),
  .config_done(config_done),
  .slew_fast_cfg(slew_fast_cfg),
  .user_in(user_in),
  .pad_o(pad_o),
  .pad_oe(pad_oe),
  .pad_slew_fast(pad_slew_fast),
  .output_clk(output_clk)
);

// ==== testbench/ioc_pad_model.sv ====
// pad beyond the cell: driven data loops back, else outside level
`timescale 1ns/1ps
module ioc_pad_model (
  input wire logic pad_o,
  input wire logic pad_oe,
  input wire logic ext_val,
  output logic pad_i
);
  assign pad_i = pad_oe ? pad_o : ext_val;
endmodule : ioc_pad_model

// ==== testbench/tb_top.sv ====
// io cell testbench
`timescale 1ns/1ps
module tb_top;
  import ioc_pkg::*;
  logic clk = 1'h0;
  logic reset = 1'h1;
  logic pad_i;
  logic user_out = 1'h0;
  logic user_oe = 1'h0;
  logic cell_clock_enable = 1'h0;
  logic cell_clock_enable_connected = 1'h1;
  ioc_ce_target_e ce_target = IOC_CE_NONE;
  logic in_is_latch = 1'h0;
  logic fast_capture_en = 1'h1;
  ioc_omux_e omux_mode = IOC_OMUX_SELECT;
  logic config_done = 1'h0;
  logic slew_fast_cfg = 1'h1;
  logic ext_val = 1'h1;
  logic user_in;
  logic pad_o;
  logic pad_oe;
  logic pad_slew_fast;
  logic output_clk;
  int fails = 0;
  int n_compared = 0;
  int n;
  always #12.5 clk = ~clk;
  ioc_cell u_ioc_cell (.clk, .reset, .pad_i, .user_out, .user_oe, .cell_clock_enable,
    .cell_clock_enable_connected, .ce_target, .in_is_latch, .fast_capture_en, .omux_mode,
    .config_done, .slew_fast_cfg, .user_in, .pad_o, .pad_oe, .pad_slew_fast, .output_clk);
  ioc_pad_model u_ioc_pad_model (.pad_o, .pad_oe, .ext_val, .pad_i);
  task automatic cyc(input int k);
    repeat (k) @(posedge clk);
    #2;
  endtask : cyc
  task automatic cmp(input logic got, input logic exp);
    n_compared++;
    if (got !== exp) begin
      fails++;
      $display("ERROR %0t got %b expected %b", $time, got, exp);
    end
  endtask : cmp
  // pad_o highs over two output clock periods
  task automatic hi8(output int cnt);
    cnt = 0;
    repeat (8) begin
      cyc(1);
      cnt += int'(pad_o === 1'h1);
    end
  endtask : hi8
  // returns just after the edge on which output_clk rises
  task automatic sync_oclk;
    while (output_clk !== 1'h0) cyc(1);
    while (output_clk !== 1'h1) cyc(1);
  endtask : sync_oclk
  task automatic summarize;
    $display("compared %0d failed %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : summarize
  task automatic t_capture;
    cyc(8);
    cmp(user_in, 1'h1);
    ext_val = 1'h0;
    in_is_latch = 1'h1;
    cyc(8);
    cmp(user_in, 1'h0);
    $display("capture test done");
  endtask : t_capture
  task automatic t_gate;
    ce_target = IOC_CE_INPUT;
    ext_val = 1'h1;
    cyc(8);
    cmp(user_in, 1'h0);
    cell_clock_enable_connected = 1'h0;
    cyc(8);
    cmp(user_in, 1'h1);
    cell_clock_enable_connected = 1'h1;
    ce_target = IOC_CE_OUTPUT;
    ext_val = 1'h0;
    cyc(8);
    cmp(user_in, 1'h0);
    $display("gate test done");
  endtask : t_gate
  task automatic t_mux;
    ce_target = IOC_CE_NONE;
    user_out = 1'h1;
    cyc(8);
    hi8(n);
    cmp(n == 4, 1'h1);
    ce_target = IOC_CE_OUTPUT;
    user_out = 1'h0;
    hi8(n);
    cmp(n == 4, 1'h1);
    omux_mode = IOC_OMUX_AND;
    ce_target = IOC_CE_NONE;
    cell_clock_enable = 1'h1;
    user_out = 1'h1;
    cyc(8);
    cmp(pad_o, 1'h1);
    cell_clock_enable = 1'h0;
    cyc(2);
    cmp(pad_o, 1'h0);
    omux_mode = IOC_OMUX_SELECT;
    $display("mux test done");
  endtask : t_mux
  task automatic t_fast;
    in_is_latch = 1'h0;
    ce_target = IOC_CE_NONE;
    ext_val = 1'h1;
    sync_oclk();
    cyc(3);
    cmp(output_clk, 1'h0);
    ext_val = 1'h0;
    cyc(1);
    cmp(output_clk, 1'h1);
    cmp(user_in, 1'h1);
    fast_capture_en = 1'h0;
    ext_val = 1'h1;
    cyc(3);
    ext_val = 1'h0;
    cyc(1);
    cmp(user_in, 1'h0);
    fast_capture_en = 1'h1;
    ce_target = IOC_CE_BOTH;
    ext_val = 1'h1;
    user_out = 1'h0;
    cyc(8);
    cmp(user_in, 1'h0);
    hi8(n);
    cmp(n == 4, 1'h1);
    $display("fast capture test done");
  endtask : t_fast
  task automatic t_soft;
    user_oe = 1'h1;
    cyc(4);
    cmp(pad_oe, 1'h0);
    config_done = 1'h1;
    cyc(3);
    cmp(pad_oe, 1'h1);
    cyc(SOFT_START_CYCLES - 2);
    cmp(pad_slew_fast, 1'h0);
    cyc(1);
    cmp(pad_slew_fast, 1'h1);
    slew_fast_cfg = 1'h0;
    cyc(2);
    cmp(pad_slew_fast, 1'h0);
    $display("soft start test done");
  endtask : t_soft
  initial begin
    cyc(10);
    reset = 1'h0;
    t_capture();
    t_gate();
    t_mux();
    t_fast();
    t_soft();
    summarize();
  end
  initial begin
    #(25 * 400);
    fails++;
    summarize();
  end
endmodule : tb_top
